// ==== core/wsm_regs.svh ====
// Register offsets, reset values and timing constants of the weld step
// monitor sequencer. Assumes a 32-bit APB with byte addresses.
`ifndef WSM_REGS_SVH
`define WSM_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define WSM_OFS_CTRL    8'h00
`define WSM_OFS_TIMES   8'h04
`define WSM_OFS_PULSE   8'h08
`define WSM_OFS_FLIM    8'h0C
`define WSM_OFS_FTRIG   8'h10
`define WSM_OFS_CLIM    8'h14
`define WSM_OFS_CSET    8'h18
`define WSM_OFS_STATUS  8'h1C
`define WSM_OFS_ERR     8'h20

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WSM_RST_CTRL    32'h0000_0200
`define WSM_RST_PULSE   32'h0000_0001
`define WSM_RST_ZERO    32'h0000_0000

// ----------------------------------------------------------------------
// Limits and timing
// ----------------------------------------------------------------------
`define WSM_PCT_MAX       7'h63
`define WSM_PCT_FULL      8'h64
`define WSM_SENSE_OFF     2'h0
`define WSM_SENSE_RISE    2'h1
`define WSM_SENSE_FALL    2'h2
`define WSM_CLK_HZ        64'd50000000
`define WSM_TRIG_WAIT_S   64'd60

`endif

// ==== core/wsm_pkg.sv ====
// Types shared by the weld step monitor sequencer.
// Assumes wsm_regs.svh for offsets and reset values.
package wsm_pkg;

  typedef enum logic [2:0] {ST_IDLE, ST_SQUEEZE, ST_TRIG_WAIT, ST_HEAT, ST_COOL,
                            ST_OFF} wsm_state_t;

  typedef struct packed {
    logic [18:0] rsv;
    logic [3:0]  contactor;
    logic        cc_mode;
    logic        width_mon;
    logic        cur_pre;
    logic        cur_mon;
    logic        force_pre;
    logic        force_mon;
    logic [1:0]  sense_mode;
    logic        start;
  } wsm_ctrl_t;

  typedef struct packed {
    logic r3; logic [6:0] slope;
    logic r2; logic [6:0] first_cool_interval;
    logic r1; logic [6:0] first_weld_interval;
    logic r0; logic [6:0] squeeze;
  } wsm_times_t;

  typedef struct packed {
    logic r3; logic [6:0] width_lo;
    logic r2; logic [6:0] width_hi;
    logic r1; logic [6:0] heat;
    logic r0; logic [6:0] impulses;
  } wsm_pulse_t;

  typedef struct packed {
    logic [15:0] lo;
    logic [15:0] hi;
  } wsm_lim_t;

  typedef struct packed {
    logic [8:0]  rsv;
    logic [6:0]  offset;
    logic [15:0] value;
  } wsm_set_t;

  typedef struct packed {
    logic er52; logic er51; logic er50; logic er49; logic er28; logic er27;
    logic er20; logic er19; logic er18; logic er17; logic er15;
  } wsm_err_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } wsm_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } wsm_apb_rsp_t;

endpackage : wsm_pkg

// ==== core/wsm_seq.sv ====
// Weld step monitor sequencer: squeeze, pressure trigger wait, first weld
// with cool and slope, end-of-interval limit checks, APB register slave.
// Assumes an APB master on clk and asynchronous pins from the power stage.
`timescale 1ns/1ps
`include "wsm_regs.svh"

module wsm_seq #(
  parameter logic [31:0] TRIG_WAIT_CYC = 32'(`WSM_TRIG_WAIT_S * `WSM_CLK_HZ)
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire wsm_pkg::wsm_apb_req_t apb_req,
  output wsm_pkg::wsm_apb_rsp_t      apb_rsp,
  // Pins from sensor and power stage
  input  wire logic                  zero_cross,
  input  wire logic [15:0]           sensor_value,
  input  wire logic [15:0]           meas_current,
  // Outputs to power stage and valve
  output logic [7:0]                 contactor_on,
  output logic [6:0]                 fire_width,
  output logic                       valve_not_ready,
  output logic                       valve_fault,
  output logic                       seq_busy
);
  import wsm_pkg::*;

  if (TRIG_WAIT_CYC < 32'd2)
  begin : g_bad_wait
    $error("TRIG_WAIT_CYC must be at least 2");
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    wsm_state_t  st;
    logic [7:0]  cnt;
    logic [6:0]  imp;
    logic [6:0]  sidx;
    logic [6:0]  base;
    logic [6:0]  width;
    logic [27:0] isum;
    logic [20:0] wsum;
    logic [14:0] ncyc;
    logic [31:0] tmo;
    wsm_err_t    err;
    wsm_ctrl_t   ctrl;
    wsm_times_t  times;
    wsm_pulse_t  pulse;
    wsm_lim_t    flim;
    wsm_set_t    ftrig;
    wsm_lim_t    clim;
    wsm_set_t    cset;
    logic [2:0]  zc;
    logic [15:0] sens1;
    logic [15:0] sens2;
    logic [15:0] cur1;
    logic [15:0] cur2;
    logic [31:0] prdata;
  } wsm_core_t;

  wsm_core_t r;
  wsm_core_t next_r;

  // ----------------------------------------------------------------------
  // Combinational helpers
  // ----------------------------------------------------------------------
  logic        tick;
  logic        wr;
  logic        rd_setup;
  logic        mapped;
  logic        sq_end;
  logic        reached;
  logic        heat_on;
  logic [7:0]  weld_len;
  logic [6:0]  width_eff;
  logic [47:0] v100;
  logic [47:0] s100;
  logic [47:0] n48;
  logic        fire_ok;

  assign tick     = r.zc[1] & ~r.zc[2];
  assign wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign mapped   = (apb_req.paddr <= `WSM_OFS_ERR) && (apb_req.paddr[1:0] == 2'h0);
  assign sq_end   = (r.cnt == 8'h00) | (tick & (r.cnt == 8'h01));
  assign heat_on  = (r.st == ST_HEAT) && (r.cnt != 8'h00);
  assign weld_len = 8'(r.times.first_weld_interval) + 8'(r.times.slope);
  assign reached  = (r.ctrl.sense_mode == `WSM_SENSE_FALL) ?
                    (r.sens2 <= r.ftrig.value) : (r.sens2 >= r.ftrig.value);
  assign fire_ok  = (r.ctrl.contactor >= 4'h1) && (r.ctrl.contactor <= 4'h8);
  // Ramp toward the regulated width over the slope cycles
  assign width_eff = (r.sidx < r.times.slope) ?
    7'((14'(r.base) * 14'(r.sidx + 7'h01)) / 14'(r.times.slope + 7'h01)) : r.base;
  assign v100 = 48'(r.sens2) * 48'(`WSM_PCT_FULL);

  always_comb
  begin
    next_r = r;
    next_r.zc     = {r.zc[1:0], zero_cross};
    next_r.sens1  = sensor_value;
    next_r.sens2  = r.sens1;
    next_r.cur1   = meas_current;
    next_r.cur2   = r.cur1;
    next_r.width  = heat_on ? width_eff : 7'h00;
    s100 = 48'h0;
    n48  = 48'h0;

    // ---------------------------------------------------------------------
    // APB register access
    // ---------------------------------------------------------------------
    if (rd_setup)
    begin
      case (apb_req.paddr)
        `WSM_OFS_CTRL:   next_r.prdata = r.ctrl;
        `WSM_OFS_TIMES:  next_r.prdata = r.times;
        `WSM_OFS_PULSE:  next_r.prdata = r.pulse;
        `WSM_OFS_FLIM:   next_r.prdata = r.flim;
        `WSM_OFS_FTRIG:  next_r.prdata = r.ftrig;
        `WSM_OFS_CLIM:   next_r.prdata = r.clim;
        `WSM_OFS_CSET:   next_r.prdata = r.cset;
        `WSM_OFS_STATUS: next_r.prdata = {25'h0, valve_not_ready, seq_busy, 2'h0, r.st};
        `WSM_OFS_ERR:    next_r.prdata = {21'h0, r.err};
        default:         next_r.prdata = 32'h0000_0000;
      endcase
    end
    if (wr)
    begin
      case (apb_req.paddr)
        `WSM_OFS_CTRL:  next_r.ctrl  = wsm_ctrl_t'({apb_req.pwdata[31:1], 1'b0});
        `WSM_OFS_TIMES: next_r.times = apb_req.pwdata;
        `WSM_OFS_PULSE: next_r.pulse = apb_req.pwdata;
        `WSM_OFS_FLIM:  next_r.flim  = apb_req.pwdata;
        `WSM_OFS_FTRIG: next_r.ftrig = apb_req.pwdata;
        `WSM_OFS_CLIM:  next_r.clim  = apb_req.pwdata;
        `WSM_OFS_CSET:  next_r.cset  = apb_req.pwdata;
        // Write one to clear; a same-cycle error below overrides the clear
        `WSM_OFS_ERR:   next_r.err   = r.err & ~apb_req.pwdata[10:0];
        default:        next_r.prdata = r.prdata;
      endcase
      // Offsets above 99 percent saturate
      if (apb_req.paddr == `WSM_OFS_FTRIG && apb_req.pwdata[22:16] > `WSM_PCT_MAX)
        next_r.ftrig.offset = `WSM_PCT_MAX;
      if (apb_req.paddr == `WSM_OFS_CSET && apb_req.pwdata[22:16] > `WSM_PCT_MAX)
        next_r.cset.offset = `WSM_PCT_MAX;
    end

    // ---------------------------------------------------------------------
    // Sequence
    // ---------------------------------------------------------------------
    case (r.st)
      ST_IDLE, ST_OFF:
      begin
        if (wr && apb_req.paddr == `WSM_OFS_CTRL && apb_req.pwdata[0])
        begin
          next_r.st   = ST_SQUEEZE;
          next_r.cnt  = 8'(r.times.squeeze);
          next_r.imp  = r.pulse.impulses;
          next_r.sidx = 7'h00;
          next_r.base = r.pulse.heat;
          next_r.isum = 28'h0;
          next_r.wsum = 21'h0;
          next_r.ncyc = 15'h0;
        end
      end
      ST_SQUEEZE:
      begin
        if (tick && r.cnt != 8'h00)
          next_r.cnt = r.cnt - 8'h01;
        if (sq_end)
        begin
          if (r.ctrl.force_mon)
          begin
            if (r.sens2 >= r.flim.hi) next_r.err.er17 = 1'b1;
            if (r.sens2 <= r.flim.lo) next_r.err.er18 = 1'b1;
            if (r.ctrl.force_pre && v100 >= 48'(r.flim.hi) *
                48'(`WSM_PCT_FULL - 8'(r.ftrig.offset)))
              next_r.err.er49 = 1'b1;
            if (r.ctrl.force_pre && v100 <= 48'(r.flim.lo) *
                48'(`WSM_PCT_FULL + 8'(r.ftrig.offset)))
              next_r.err.er50 = 1'b1;
          end
          next_r.tmo = 32'h0;
          next_r.cnt = weld_len;
          if (r.ctrl.sense_mode == `WSM_SENSE_OFF || r.ctrl.sense_mode == 2'h3 || reached)
            next_r.st = ST_HEAT;
          else
            next_r.st = ST_TRIG_WAIT;
        end
      end
      ST_TRIG_WAIT:
      begin
        next_r.tmo = r.tmo + 32'h1;
        if (reached)
          next_r.st = ST_HEAT;
        else if (r.tmo >= TRIG_WAIT_CYC - 32'h1)
        begin
          next_r.st = ST_OFF;
          next_r.err.er15 = 1'b1;
        end
      end
      ST_HEAT:
      begin
        if (tick && r.cnt != 8'h00)
        begin
          next_r.cnt  = r.cnt - 8'h01;
          next_r.isum = r.isum + 28'(r.cur2);
          next_r.wsum = r.wsum + 21'(width_eff);
          next_r.ncyc = r.ncyc + 15'h1;
          if (r.sidx < r.times.slope)
            next_r.sidx = r.sidx + 7'h01;
          if (r.ctrl.cc_mode && r.cur2 < r.cset.value && r.base < `WSM_PCT_MAX)
            next_r.base = r.base + 7'h01;
          else if (r.ctrl.cc_mode && r.cur2 > r.cset.value && r.base != 7'h00)
            next_r.base = r.base - 7'h01;
        end
        if (sq_end && r.imp > 7'h01)
        begin
          next_r.st  = ST_COOL;
          next_r.imp = r.imp - 7'h01;
          next_r.cnt = 8'(r.times.first_cool_interval);
        end
        else if (sq_end)
        begin
          next_r.st = ST_IDLE;
          n48  = 48'(next_r.ncyc);
          s100 = 48'(next_r.isum) * 48'(`WSM_PCT_FULL);
          // Averages compared as sums against limit times cycle count
          if (n48 != 48'h0 && r.ctrl.cur_mon)
          begin
            if (48'(next_r.isum) >= 48'(r.clim.hi) * n48) next_r.err.er19 = 1'b1;
            if (48'(next_r.isum) <= 48'(r.clim.lo) * n48) next_r.err.er20 = 1'b1;
            if (r.ctrl.cur_pre && s100 >= 48'(r.clim.hi) *
                48'(`WSM_PCT_FULL - 8'(r.cset.offset)) * n48)
              next_r.err.er51 = 1'b1;
            if (r.ctrl.cur_pre && s100 <= 48'(r.clim.lo) *
                48'(`WSM_PCT_FULL + 8'(r.cset.offset)) * n48)
              next_r.err.er52 = 1'b1;
          end
          if (n48 != 48'h0 && r.ctrl.width_mon)
          begin
            if (48'(next_r.wsum) >= 48'(r.pulse.width_hi) * n48) next_r.err.er27 = 1'b1;
            if (48'(next_r.wsum) <= 48'(r.pulse.width_lo) * n48) next_r.err.er28 = 1'b1;
          end
        end
      end
      ST_COOL:
      begin
        if (tick && r.cnt != 8'h00)
          next_r.cnt = r.cnt - 8'h01;
        if (sq_end)
        begin
          next_r.st  = ST_HEAT;
          next_r.cnt = weld_len;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.ctrl  <= `WSM_RST_CTRL;
      r.pulse <= `WSM_RST_PULSE;
    end
    else
      r <= next_r;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Contactor enable follows the registered firing width cycle by cycle
  assign contactor_on    = (r.width != 7'h00 && fire_ok) ?
                           (8'h01 << (r.ctrl.contactor - 4'h1)) : 8'h00;
  assign fire_width      = r.width;
  assign valve_not_ready = (r.st == ST_TRIG_WAIT);
  assign valve_fault     = r.err.er15;
  assign seq_busy        = (r.st != ST_IDLE) && (r.st != ST_OFF);
  assign apb_rsp.prdata  = r.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_sq_end;
    (r.st == ST_SQUEEZE) && sq_end;
  endsequence

  a_sense_off_skip: assert property (s_sq_end ##0 (r.ctrl.sense_mode == 2'h0)
    |=> r.st == ST_HEAT) else $error("sensing off did not skip");
  a_rise_wait: assert property (s_sq_end ##0 (r.ctrl.sense_mode == 2'h1) ##0
    (r.sens2 < r.ftrig.value) |=> r.st == ST_TRIG_WAIT) else $error("rise wait");
  a_fall_wait: assert property (s_sq_end ##0 (r.ctrl.sense_mode == 2'h2) ##0
    (r.sens2 > r.ftrig.value) |=> r.st == ST_TRIG_WAIT) else $error("fall wait");
  a_wait_flag: assert property (r.st == ST_TRIG_WAIT |-> valve_not_ready && seq_busy)
    else $error("ready flag missing in wait");
  a_wait_timeout: assert property (r.st == ST_TRIG_WAIT && r.tmo == TRIG_WAIT_CYC - 32'h1
    && !reached |=> r.st == ST_OFF && valve_fault) else $error("no timeout");
  a_one_contactor: assert property (contactor_on != 8'h00 |-> $onehot(contactor_on) &&
    contactor_on[3'(r.ctrl.contactor - 4'h1)]) else $error("wrong contactor");
  a_phase_width: assert property (heat_on && !r.ctrl.cc_mode && r.sidx >= r.times.slope
    |=> fire_width == $past(r.pulse.heat)) else $error("phase width wrong");
  a_cc_step: assert property (r.st == ST_HEAT && tick && r.cnt != 8'h00 && r.ctrl.cc_mode
    && r.cur2 < r.cset.value && r.base < 7'h63 |=> r.base == $past(r.base) + 7'h01)
    else $error("current loop did not raise width");
  a_cur_high: assert property (r.st == ST_HEAT && sq_end && r.imp <= 7'h01 && r.ctrl.cur_mon
    |=> r.ncyc == 15'h0 || 48'(r.isum) < 48'(r.clim.hi) * 48'(r.ncyc) || r.err.er19)
    else $error("high current not flagged");
  a_force_high: assert property (s_sq_end ##0 r.ctrl.force_mon ##0 (r.sens2 >= r.flim.hi)
    |=> r.err.er17) else $error("high force not flagged");

endmodule : wsm_seq

// ==== tb/wsm_partner.sv ====
// Model of the mains supply, pressure sensor and thyristor power stage.
// Assumes the bench commands the pressure level on rising clock edges.
`timescale 1ns/1ps

module wsm_partner #(
  parameter int HALF_LINE = 20
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // From the sequencer
  input  wire logic [7:0]  contactor_on,
  input  wire logic [6:0]  fire_width,
  // Commanded by the bench
  input  wire logic [15:0] pressure_level,
  // To the sequencer
  output logic             zero_cross,
  output logic [15:0]      sensor_value,
  output logic [15:0]      meas_current
);
  int line_cnt;

  // ----------------------------------------------------------------------
  // Mains, sensor and load
  // ----------------------------------------------------------------------
  // Shortened line period keeps runs brief; mains runs free
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_cnt     <= 0;
      zero_cross   <= 1'b0;
      sensor_value <= 16'h0000;
      meas_current <= 16'h0000;
    end
    else
    begin
      line_cnt <= (line_cnt == HALF_LINE - 1) ? 0 : line_cnt + 1;
      if (line_cnt == HALF_LINE - 1)
        zero_cross <= ~zero_cross;
      sensor_value <= pressure_level;
      // Linear load: 1 percent of width gives 1.00 kA
      meas_current <= (contactor_on != 8'h00) ? 16'(fire_width) * 16'h0064 : 16'h0000;
    end
  end
endmodule : wsm_partner

// ==== tb/test_weld_step_monitor_sequencer.sv ====
// Self-checking bench of the weld step monitor sequencer.
// Assumes wsm_pkg, wsm_regs.svh and the partner model are compiled first.
`timescale 1ns/1ps
`include "wsm_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("unexpected %s exp %0h seen %0h", nm, ex, got); end end
`define WAIT_FOR(c) begin n = 0; while (!(c) && n < 4000) begin @(negedge clk); n++; end end

module test_weld_step_monitor_sequencer;
  import wsm_pkg::*;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  wsm_apb_req_t apb_req = '0;
  wsm_apb_rsp_t apb_rsp;
  logic         zero_cross;
  logic [15:0]  sensor_value;
  logic [15:0]  meas_current;
  logic [15:0]  pressure_level = 16'h0000;
  logic [7:0]   contactor_on;
  logic [6:0]   fire_width;
  logic         valve_not_ready;
  logic         valve_fault;
  logic         seq_busy;
  logic [31:0]  rd;
  logic         er;
  int fail_count = 0, checked = 0, cycles = 0, seed = 72, n, n2, i;
  int s, fm, fp, foff, fhi, flo, cm, cp, coff, chi, clo, wm, whi, wlo, heat;
  logic [7:0]   addrs [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
  logic [31:0]  rsts  [9] = '{32'h200, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  wsm_seq #(.TRIG_WAIT_CYC(32'd200)) wsm_seq_i (
    .clk(clk), .arst_n(arst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .zero_cross(zero_cross), .sensor_value(sensor_value), .meas_current(meas_current),
    .contactor_on(contactor_on), .fire_width(fire_width), .valve_not_ready(valve_not_ready),
    .valve_fault(valve_fault), .seq_busy(seq_busy));

  wsm_partner #(.HALF_LINE(20)) wsm_partner_i (
    .clk(clk), .arst_n(arst_n), .contactor_on(contactor_on), .fire_width(fire_width),
    .pressure_level(pressure_level), .zero_cross(zero_cross), .sensor_value(sensor_value),
    .meas_current(meas_current));

  always #10 clk = ~clk;

  // ----------------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------------
  task complete_run();
    $display("counts: %0d checks, %0d mismatches", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      $display("unexpected hang, cycle limit reached");
      complete_run();
    end
  end

  // ----------------------------------------------------------------------
  // APB master and reference model
  // ----------------------------------------------------------------------
  task apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    do @(posedge clk); while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb_xfer

  task rd_chk(input logic [7:0] a, input logic [31:0] ex, input string nm);
    apb_xfer(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask : rd_chk

  // Counts falling edges while the firing width stays nonzero
  task count_on();
    n2 = 0;
    while (fire_width !== 7'h00 && n2 < 1000)
    begin
      @(negedge clk);
      n2++;
    end
  endtask : count_on

  function automatic logic [31:0] exp_err();
    int e = 0;
    int a = heat * 100;
    if (fm != 0)
    begin
      if (s >= fhi) e |= 2;
      if (s <= flo) e |= 4;
      if (fp != 0 && s * 100 >= fhi * (100 - foff)) e |= 128;
      if (fp != 0 && s * 100 <= flo * (100 + foff)) e |= 256;
    end
    if (cm != 0)
    begin
      if (a >= chi) e |= 8;
      if (a <= clo) e |= 16;
      if (cp != 0 && a * 100 >= chi * (100 - coff)) e |= 512;
      if (cp != 0 && a * 100 <= clo * (100 + coff)) e |= 1024;
    end
    if (wm != 0 && heat >= whi) e |= 32;
    if (wm != 0 && heat <= wlo) e |= 64;
    return 32'(e);
  endfunction : exp_err

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 9; i++) rd_chk(addrs[i], rsts[i], "reset value");
    apb_xfer(1'b0, 8'h24, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h0, rd)
    apb_xfer(1'b1, `WSM_OFS_FTRIG, 32'h007F_0000);
    rd_chk(`WSM_OFS_FTRIG, 32'h0063_0000, "offset saturation");
    $display("test registers done");

    // Random limits, all eight contactors, sensing off or code 3
    for (i = 1; i <= 8; i++)
    begin
      heat = 1 + $unsigned($random(seed)) % 99;
      s = $unsigned($random(seed)) % 2000;
      fhi = 500 + $unsigned($random(seed)) % 1000;
      flo = $unsigned($random(seed)) % 800;
      foff = $unsigned($random(seed)) % 100;
      chi = $unsigned($random(seed)) % (heat * 200 + 1);
      clo = $unsigned($random(seed)) % (heat * 200 + 1);
      coff = $unsigned($random(seed)) % 100;
      whi = $unsigned($random(seed)) % 100;
      wlo = $unsigned($random(seed)) % 100;
      {fm, fp, cm, cp, wm} = {5{32'(i % 2)}} ^ {32'($random(seed) & 1), 32'($random(seed) & 1),
        32'($random(seed) & 1), 32'(1), 32'(0)};
      apb_xfer(1'b1, `WSM_OFS_TIMES, 32'h0001_0201);
      apb_xfer(1'b1, `WSM_OFS_PULSE, {1'b0, 7'(wlo), 1'b0, 7'(whi), 1'b0, 7'(heat), 8'h02});
      apb_xfer(1'b1, `WSM_OFS_FLIM, {16'(flo), 16'(fhi)});
      apb_xfer(1'b1, `WSM_OFS_FTRIG, {9'h000, 7'(foff), 16'hFFFF});
      apb_xfer(1'b1, `WSM_OFS_CLIM, {16'(clo), 16'(chi)});
      apb_xfer(1'b1, `WSM_OFS_CSET, {9'h000, 7'(coff), 16'h0000});
      pressure_level <= 16'(s);
      apb_xfer(1'b1, `WSM_OFS_CTRL, {19'h0, 4'(i), 1'b0, 1'(wm), 1'(cp), 1'(cm), 1'(fp),
        1'(fm), (i % 2 == 1) ? 2'h3 : 2'h0, 1'b1});
      `WAIT_FOR(fire_width !== 7'h00)
      `CHK("valve not ready", 1'b0, valve_not_ready)
      `CHK("fire width", 7'(heat), fire_width)
      `CHK("contactor", 8'h01 << (i - 1), contactor_on)
      // Heat starts on a tick here, so two whole line cycles of 40 clocks
      count_on();
      `CHK("weld length", 80, n2)
      `WAIT_FOR(seq_busy === 1'b0)
      rd_chk(`WSM_OFS_ERR, exp_err(), "errors");
      apb_xfer(1'b1, `WSM_OFS_ERR, 32'h0000_07FF);
      rd_chk(`WSM_OFS_ERR, 32'h0, "errors cleared");
    end
    $display("test limit checks done");

    // Rising trigger wait, then three weld cycles plus one slope cycle
    apb_xfer(1'b1, `WSM_OFS_TIMES, 32'h0100_0301);
    apb_xfer(1'b1, `WSM_OFS_PULSE, 32'h0000_2801);
    apb_xfer(1'b1, `WSM_OFS_FTRIG, 32'h0000_01F4);
    pressure_level <= 16'h000A;
    apb_xfer(1'b1, `WSM_OFS_CTRL, 32'h0000_0603);
    `WAIT_FOR(valve_not_ready === 1'b1)
    rd_chk(`WSM_OFS_STATUS, 32'h0000_0062, "waiting status");
    pressure_level <= 16'h01F4;
    `WAIT_FOR(fire_width !== 7'h00)
    `CHK("wait released", 1'b0, valve_not_ready)
    `CHK("slope start width", 7'h14, fire_width)
    // Heat after a wait starts mid line cycle: first tick comes 1 to 40 clocks late
    count_on();
    `CHK("weld length", 1'b1, n2 > 120 && n2 <= 160)
    $display("test rising wait done");

    // Falling trigger never met: abandon to off state
    apb_xfer(1'b1, `WSM_OFS_FTRIG, 32'h0000_0064);
    pressure_level <= 16'h07D0;
    apb_xfer(1'b1, `WSM_OFS_CTRL, 32'h0000_0605);
    `WAIT_FOR(valve_not_ready === 1'b1)
    n2 = 0;
    while (valve_fault !== 1'b1 && n2 < 1000)
    begin
      @(negedge clk);
      n2++;
    end
    `CHK("timeout window", 1'b1, n2 >= 195 && n2 <= 205)
    rd_chk(`WSM_OFS_STATUS, 32'h0000_0005, "off status");
    rd_chk(`WSM_OFS_ERR, 32'h0000_0001, "valve fault code");
    apb_xfer(1'b1, `WSM_OFS_ERR, 32'h0000_0001);
    @(negedge clk);
    `CHK("valve fault cleared", 1'b0, valve_fault)
    $display("test timeout done");

    // Constant current far above reach: width climbs one percent per tick
    apb_xfer(1'b1, `WSM_OFS_TIMES, 32'h0000_0401);
    apb_xfer(1'b1, `WSM_OFS_PULSE, 32'h0000_0A01);
    apb_xfer(1'b1, `WSM_OFS_CSET, 32'h0000_0BB8);
    apb_xfer(1'b1, `WSM_OFS_CTRL, 32'h0000_0501);
    n2 = 0;
    n = 0;
    do
    begin
      @(negedge clk);
      if (fire_width !== 7'h00) n2 = fire_width;
      n++;
    end
    while (seq_busy !== 1'b0 && n < 4000);
    // Last fired width: heat 10 plus three raises; the raise on the fourth tick lands as heat ends
    `CHK("regulated width", 13, n2)
    $display("test constant current done");
    complete_run();
  end
endmodule : test_weld_step_monitor_sequencer
